// ===== pps_defs.vh
// Purpose: constants for the programming port select block
// Assumes: APB slave, 32-bit data, one aligned word per register
// Notes:   offsets are byte addresses; reserved bits read as zero
`ifndef PPS_DEFS_VH
`define PPS_DEFS_VH

// register byte offsets
`define PPS_ADDR_CONFIG      12'h000
`define PPS_ADDR_STATUS      12'h004
`define PPS_ADDR_ERASE       12'h008

// configuration word fields
`define PPS_CFG_DED_PORT     0
`define PPS_CFG_DEBUG_OFF    1
`define PPS_CFG_SINGLE_SUP   2
`define PPS_CFG_CODE_PROT    3
`define PPS_CFG_RESET        4'h6

// status word fields
`define PPS_ST_PROG_MODE     0
`define PPS_ST_HV_ENTRY      1
`define PPS_ST_DED_ACTIVE    2
`define PPS_ST_REDUCED       3
`define PPS_ST_DEBUG_EN      4
`define PPS_ST_MODE_PIN_GPIO 5
`define PPS_ST_CFG_REFUSED   6
`define PPS_ST_ERASE_REFUSED 7

// erase command fields
`define PPS_ER_BLOCK         0
`define PPS_ER_ROW           1

// synchronised pin vector positions
`define PPS_P_LEG_LVL        0
`define PPS_P_LEG_HV         1
`define PPS_P_LEG_CLK        2
`define PPS_P_LEG_DAT        3
`define PPS_P_DED_LVL        4
`define PPS_P_DED_HV         5
`define PPS_P_DED_CLK        6
`define PPS_P_DED_DAT        7
`define PPS_P_EMU_SEL        8
`define PPS_P_MODE_PIN       9
`define PPS_P_WIDTH          10

`endif

// ===== pps_sync.v
// Purpose: two-stage synchroniser for a vector of pin levels
// Assumes: each bit is an independent level from outside the clock domain
// Notes:   first stage feeds only the second stage
`timescale 1ns/1ps
`default_nettype none
module pps_sync #(
    parameter WIDTH = 1
) (
    input  wire             clk_i,
    input  wire             rst_n_i,
    input  wire [WIDTH-1:0] async_i,
    output reg  [WIDTH-1:0] sync_o
);
    reg [WIDTH-1:0] meta;

    // plain double flop, reset to low
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            meta   <= {WIDTH{1'b0}};
            sync_o <= {WIDTH{1'b0}};
        end else begin
            meta   <= async_i;
            sync_o <= meta;
        end
    end
endmodule // pps_sync
`default_nettype wire

// ===== pps_top.v
// Purpose: selects and gates the legacy and dedicated programming/debug ports
// Assumes: pins are asynchronous levels; MCLK_I at 200 MHz samples the
//          serial clocks; the serial engine sits on MCLK_I beside this block
// Notes:   configuration word and erase commands are reached over APB
//
// Design decisions made here: register access over APB and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "pps_defs.vh"
module pps_top (
    input  wire        MCLK_I,
    input  wire        RST_N_I,
    // apb slave
    input  wire        PSEL_I,
    input  wire        PENABLE_I,
    input  wire        PWRITE_I,
    input  wire [11:0] PADDR_I,
    input  wire [31:0] PWDATA_I,
    output reg  [31:0] PRDATA_O,
    output reg         PREADY_O,
    output reg         PSLVERR_O,
    // legacy port pins
    input  wire        LEGACY_RESET_VPP_PIN_I,
    input  wire        LEGACY_VPP_HV_I,
    input  wire        LEGACY_PROG_CLOCK_PIN_I,
    input  wire        LEGACY_PROG_DATA_PIN_I,
    output reg         LEGACY_PROG_DATA_PIN_O,
    output reg         LEGACY_PROG_DATA_PIN_OE_N_O,
    // dedicated port pins
    input  wire        DEDICATED_RESET_VPP_PIN_I,
    input  wire        DEDICATED_VPP_HV_I,
    input  wire        DEDICATED_PROG_CLOCK_PIN_I,
    input  wire        DEDICATED_PROG_DATA_PIN_I,
    output reg         DEDICATED_PROG_DATA_PIN_O,
    output reg         DEDICATED_PROG_DATA_PIN_OE_N_O,
    // mode pins
    input  wire        EMULATION_SELECT_PIN_I,
    input  wire        PROG_MODE_ENTRY_PIN_I,
    // serial engine side
    input  wire        SER_DATA_OUT_I,
    input  wire        SER_DATA_DRIVE_I,
    output reg         SER_CLK_RISE_O,
    output reg         SER_CLK_FALL_O,
    output reg         SER_DATA_O,
    // device side
    output reg         DEVICE_RESET_O,
    output reg         PROG_MODE_O,
    output reg         DEBUG_ENABLE_O,
    output reg         REDUCED_PACKAGE_O,
    output reg         MODE_PIN_GPIO_O,
    output reg         ERASE_BLOCK_O,
    output reg         ERASE_ROW_O
);
    // session sources
    localparam SRC_NONE  = 2'b00;
    localparam SRC_LEG_H = 2'b01;
    localparam SRC_LEG_L = 2'b10;
    localparam SRC_DED_H = 2'b11;

    wire [`PPS_P_WIDTH-1:0] pin_raw;
    wire [`PPS_P_WIDTH-1:0] pin;
    reg  [3:0]              cfg;
    reg  [1:0]              src;
    reg  [1:0]              next_src;
    reg                     ded_sel;
    reg                     next_ded_sel;
    reg                     leg_clk_d;
    reg                     ded_clk_d;
    reg                     cfg_refused;
    reg                     erase_refused;
    reg  [3:0]              next_cfg;
    reg                     cfg_bad;

    // raw levels placed by their named positions, so the order cannot drift
    assign pin_raw[`PPS_P_LEG_LVL]  = LEGACY_RESET_VPP_PIN_I;
    assign pin_raw[`PPS_P_LEG_HV]   = LEGACY_VPP_HV_I;
    assign pin_raw[`PPS_P_LEG_CLK]  = LEGACY_PROG_CLOCK_PIN_I;
    assign pin_raw[`PPS_P_LEG_DAT]  = LEGACY_PROG_DATA_PIN_I;
    assign pin_raw[`PPS_P_DED_LVL]  = DEDICATED_RESET_VPP_PIN_I;
    assign pin_raw[`PPS_P_DED_HV]   = DEDICATED_VPP_HV_I;
    assign pin_raw[`PPS_P_DED_CLK]  = DEDICATED_PROG_CLOCK_PIN_I;
    assign pin_raw[`PPS_P_DED_DAT]  = DEDICATED_PROG_DATA_PIN_I;
    assign pin_raw[`PPS_P_EMU_SEL]  = EMULATION_SELECT_PIN_I;
    assign pin_raw[`PPS_P_MODE_PIN] = PROG_MODE_ENTRY_PIN_I;

    pps_sync #(
        .WIDTH (`PPS_P_WIDTH)
    ) u_sync (
        .clk_i   (MCLK_I),
        .rst_n_i (RST_N_I),
        .async_i (pin_raw),
        .sync_o  (pin)
    );

    wire ded_en   = cfg[`PPS_CFG_DED_PORT];
    wire lvp_en   = cfg[`PPS_CFG_SINGLE_SUP];
    wire dbg_en   = ~cfg[`PPS_CFG_DEBUG_OFF];
    wire leg_high = pin[`PPS_P_LEG_LVL];

    // dedicated pins count only when the port is on and legacy is not high
    wire ded_ok   = ded_en & ~leg_high;

    // entry conditions for each source
    wire leg_hv_entry = pin[`PPS_P_LEG_HV];
    wire leg_lv_entry = lvp_en & leg_high & pin[`PPS_P_MODE_PIN];
    wire ded_hv_entry = ded_ok & pin[`PPS_P_DED_HV];

    // session source selection; a running session holds until its entry drops or legacy high voltage takes over
    always @* begin
        next_src = src;
        case (src)
            SRC_NONE: begin
                if (leg_hv_entry) begin
                    next_src = SRC_LEG_H;
                end else if (ded_hv_entry) begin
                    next_src = SRC_DED_H;
                end else if (leg_lv_entry) begin
                    next_src = SRC_LEG_L;
                end
            end
            SRC_LEG_H: begin
                if (!leg_hv_entry) begin
                    next_src = SRC_NONE;
                end
            end
            SRC_LEG_L: begin
                // high voltage takes over, so the supply bit can still move
                if (leg_hv_entry) begin
                    next_src = SRC_LEG_H;
                end else if (!leg_lv_entry) begin
                    next_src = SRC_NONE;
                end
            end
            default: begin
                // legacy high voltage wins over a running dedicated session
                if (leg_hv_entry) begin
                    next_src = SRC_LEG_H;
                end else if (!ded_hv_entry) begin
                    next_src = SRC_NONE;
                end
            end
        endcase
    end

    always @(posedge MCLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            src <= SRC_NONE;
        end else begin
            src <= next_src;
        end
    end

    wire in_session = (src != SRC_NONE);
    wire hv_session = (src == SRC_LEG_H) | (src == SRC_DED_H);
    wire leg_session = (src == SRC_LEG_H) | (src == SRC_LEG_L);

    // serial clock edges on both ports; sampling keeps them in MCLK_I domain
    always @(posedge MCLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            leg_clk_d <= 1'b0;
            ded_clk_d <= 1'b0;
        end else begin
            leg_clk_d <= pin[`PPS_P_LEG_CLK];
            ded_clk_d <= pin[`PPS_P_DED_CLK];
        end
    end

    wire leg_edge = leg_clk_d ^ pin[`PPS_P_LEG_CLK];
    wire ded_edge = (ded_clk_d ^ pin[`PPS_P_DED_CLK]) & ded_ok;

    // port choice: fixed by the session, else legacy while ded_ok is low, otherwise follows the last active clock
    always @* begin
        next_ded_sel = ded_sel;
        if (in_session) begin
            next_ded_sel = (src == SRC_DED_H);
        end else if (!ded_ok) begin
            next_ded_sel = 1'b0;
        end else if (leg_edge) begin
            next_ded_sel = 1'b0;
        end else if (ded_edge) begin
            next_ded_sel = 1'b1;
        end
    end

    // registered choice steers the data pin enables
    always @(posedge MCLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            ded_sel <= 1'b0;
        end else begin
            ded_sel <= next_ded_sel;
        end
    end

    // the next choice decodes the edge that moves the port, so it is not lost
    wire sel_clk = next_ded_sel ? pin[`PPS_P_DED_CLK] : pin[`PPS_P_LEG_CLK];
    wire sel_clk_d = next_ded_sel ? ded_clk_d : leg_clk_d;
    wire link_live = in_session | dbg_en;

    // serial clock and data towards the engine
    always @(posedge MCLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            SER_CLK_RISE_O <= 1'b0;
            SER_CLK_FALL_O <= 1'b0;
            SER_DATA_O     <= 1'b0;
        end else begin
            SER_CLK_RISE_O <= link_live & sel_clk & ~sel_clk_d;
            SER_CLK_FALL_O <= link_live & ~sel_clk & sel_clk_d;
            SER_DATA_O     <= next_ded_sel ? pin[`PPS_P_DED_DAT] : pin[`PPS_P_LEG_DAT];
        end
    end

    // data pin drivers; only the selected port drives, the other floats
    always @(posedge MCLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            LEGACY_PROG_DATA_PIN_O         <= 1'b0;
            LEGACY_PROG_DATA_PIN_OE_N_O    <= 1'b1;
            DEDICATED_PROG_DATA_PIN_O      <= 1'b0;
            DEDICATED_PROG_DATA_PIN_OE_N_O <= 1'b1;
        end else begin
            LEGACY_PROG_DATA_PIN_O         <= SER_DATA_OUT_I;
            LEGACY_PROG_DATA_PIN_OE_N_O    <= ~(link_live & SER_DATA_DRIVE_I & ~ded_sel);
            DEDICATED_PROG_DATA_PIN_O      <= SER_DATA_OUT_I;
            DEDICATED_PROG_DATA_PIN_OE_N_O <= ~(link_live & SER_DATA_DRIVE_I & ded_sel
                                                & ded_ok);
        end
    end

    // device-side levels
    always @(posedge MCLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            DEVICE_RESET_O    <= 1'b1;
            PROG_MODE_O       <= 1'b0;
            DEBUG_ENABLE_O    <= 1'b0;
            REDUCED_PACKAGE_O <= 1'b0;
            MODE_PIN_GPIO_O   <= 1'b0;
        end else begin
            // legacy low resets unless an enabled dedicated pin holds high
            DEVICE_RESET_O    <= ~leg_high & ~(ded_en & pin[`PPS_P_DED_LVL]);
            PROG_MODE_O       <= in_session;
            DEBUG_ENABLE_O    <= dbg_en;
            REDUCED_PACKAGE_O <= dbg_en & ded_en
                                 & ~pin[`PPS_P_EMU_SEL];
            MODE_PIN_GPIO_O   <= ~lvp_en;
        end
    end

    // apb access strobes; one wait state, the write lands with pready
    wire acc      = PSEL_I & PENABLE_I;
    wire acc_done = acc & PREADY_O;
    wire wr_done  = acc_done & PWRITE_I;
    wire a_cfg    = (PADDR_I == `PPS_ADDR_CONFIG);
    wire a_stat   = (PADDR_I == `PPS_ADDR_STATUS);
    wire a_erase  = (PADDR_I == `PPS_ADDR_ERASE);
    wire a_ok     = a_cfg | a_stat | a_erase;

    // configuration write filter; refused bits keep their old value
    always @* begin
        next_cfg = cfg;
        cfg_bad  = 1'b0;
        if (wr_done && a_cfg) begin
            if (!in_session) begin
                cfg_bad = (PWDATA_I[3:0] != cfg);
            end else begin
                next_cfg[`PPS_CFG_DEBUG_OFF] = PWDATA_I[`PPS_CFG_DEBUG_OFF];
                next_cfg[`PPS_CFG_CODE_PROT] = PWDATA_I[`PPS_CFG_CODE_PROT];
                if (leg_session) begin
                    next_cfg[`PPS_CFG_DED_PORT] = PWDATA_I[`PPS_CFG_DED_PORT];
                end else if (PWDATA_I[`PPS_CFG_DED_PORT] != cfg[`PPS_CFG_DED_PORT]) begin
                    cfg_bad = 1'b1;
                end
                if (hv_session) begin
                    next_cfg[`PPS_CFG_SINGLE_SUP] = PWDATA_I[`PPS_CFG_SINGLE_SUP];
                end else if (PWDATA_I[`PPS_CFG_SINGLE_SUP] != lvp_en) begin
                    cfg_bad = 1'b1;
                end
            end
        end
    end

    always @(posedge MCLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            cfg <= `PPS_CFG_RESET;
        end else begin
            cfg <= next_cfg;
        end
    end

    wire er_wr     = wr_done & a_erase & in_session;
    wire er_block  = er_wr & PWDATA_I[`PPS_ER_BLOCK];
    wire er_row    = er_wr & ~PWDATA_I[`PPS_ER_BLOCK] & PWDATA_I[`PPS_ER_ROW];
    wire row_bad   = er_row & cfg[`PPS_CFG_CODE_PROT];
    wire er_lost   = wr_done & a_erase & ~in_session
                     & (PWDATA_I[`PPS_ER_BLOCK] | PWDATA_I[`PPS_ER_ROW]);
    wire clr_cfg   = wr_done & a_stat & PWDATA_I[`PPS_ST_CFG_REFUSED];
    wire clr_erase = wr_done & a_stat & PWDATA_I[`PPS_ST_ERASE_REFUSED];

    // erase pulses and sticky refusal flags; a new event beats its clear
    always @(posedge MCLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            ERASE_BLOCK_O <= 1'b0;
            ERASE_ROW_O   <= 1'b0;
            cfg_refused   <= 1'b0;
            erase_refused <= 1'b0;
        end else begin
            ERASE_BLOCK_O <= er_block;
            ERASE_ROW_O   <= er_row & ~cfg[`PPS_CFG_CODE_PROT];
            if (cfg_bad) begin
                cfg_refused <= 1'b1;
            end else if (clr_cfg) begin
                cfg_refused <= 1'b0;
            end
            if (row_bad || er_lost) begin
                erase_refused <= 1'b1;
            end else if (clr_erase) begin
                erase_refused <= 1'b0;
            end
        end
    end

    wire [7:0] status = {erase_refused, cfg_refused, MODE_PIN_GPIO_O, DEBUG_ENABLE_O,
                         REDUCED_PACKAGE_O, ded_sel, hv_session, in_session};

    // apb answer: ready one cycle into the access phase, error on a hole
    always @(posedge MCLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            PREADY_O  <= 1'b0;
            PSLVERR_O <= 1'b0;
            PRDATA_O  <= 32'h0000_0000;
        end else if (acc && !PREADY_O) begin
            PREADY_O  <= 1'b1;
            PSLVERR_O <= ~a_ok;
            if (PWRITE_I) begin
                PRDATA_O <= 32'h0000_0000;
            end else if (a_cfg) begin
                PRDATA_O <= {28'h000_0000, cfg};
            end else if (a_stat) begin
                PRDATA_O <= {24'h00_0000, status};
            end else begin
                PRDATA_O <= 32'h0000_0000;
            end
        end else begin
            PREADY_O  <= 1'b0;
            PSLVERR_O <= 1'b0;
        end
    end
endmodule // pps_top
`default_nettype wire

// ===== pps_properties.sv
// Purpose: concurrent checks on the port select block
// Assumes: pins cross a two-flop synchroniser, level outputs one flop later, PROG_MODE_O two
// Notes:   pin checks wait seven edges after reset so the pipe holds real samples
`timescale 1ns/1ps
`default_nettype none
module pps_properties (
    input wire logic MCLK_I,
    input wire logic RST_N_I,
    input wire logic PSEL_I,
    input wire logic PENABLE_I,
    input wire logic PWRITE_I,
    input wire logic PREADY_O,
    input wire logic LEGACY_RESET_VPP_PIN_I,
    input wire logic LEGACY_VPP_HV_I,
    input wire logic LEGACY_PROG_CLOCK_PIN_I,
    input wire logic DEDICATED_PROG_CLOCK_PIN_I,
    input wire logic EMULATION_SELECT_PIN_I,
    input wire logic SER_CLK_RISE_O,
    input wire logic DEVICE_RESET_O,
    input wire logic PROG_MODE_O,
    input wire logic DEBUG_ENABLE_O,
    input wire logic REDUCED_PACKAGE_O,
    input wire logic MODE_PIN_GPIO_O,
    input wire logic ERASE_BLOCK_O,
    input wire logic ERASE_ROW_O
);
    logic [2:0] up;
    logic       wr;
    // accepted apb write
    assign wr = PSEL_I && PENABLE_I && PWRITE_I && PREADY_O;
    // saturating edge count since reset
    always @(posedge MCLK_I or negedge RST_N_I)
        if (!RST_N_I) up <= 3'h0;
        else if (up != 3'h7) up <= up + 3'h1;
    default clocking cb @(posedge MCLK_I); endclocking
    default disable iff (!RST_N_I);
    debug_by_write_a :
    assert property ($changed(DEBUG_ENABLE_O) |-> $past(wr) || $past(wr, 2))
        else $error("debug enable moved without a config write");
    gpio_by_write_a :
    assert property ($changed(MODE_PIN_GPIO_O) |-> $past(wr) || $past(wr, 2))
        else $error("entry pin use moved without a config write");
    reduced_needs_debug_a :
    assert property (REDUCED_PACKAGE_O |-> DEBUG_ENABLE_O || $past(DEBUG_ENABLE_O))
        else $error("reduced package without debug enabled");
    full_package_a :
    assert property (up == 3'h7 && $past(EMULATION_SELECT_PIN_I, 3) &&
        $past(EMULATION_SELECT_PIN_I, 4) && $past(EMULATION_SELECT_PIN_I, 5) |-> !REDUCED_PACKAGE_O)
        else $error("reduced package with emulation pin high");
    clock_edge_pulse_a :
    assert property (up == 3'h7 && SER_CLK_RISE_O |->
        ($past(LEGACY_PROG_CLOCK_PIN_I, 3) && !$past(LEGACY_PROG_CLOCK_PIN_I, 4)) ||
        ($past(DEDICATED_PROG_CLOCK_PIN_I, 3) && !$past(DEDICATED_PROG_CLOCK_PIN_I, 4)))
        else $error("serial rise pulse without a pin rise three edges back");
    hv_entry_a :
    assert property (up == 3'h7 && $past(LEGACY_VPP_HV_I, 4) && $past(LEGACY_VPP_HV_I, 5)
        |-> PROG_MODE_O)
        else $error("high voltage entry not accepted");
    legacy_run_a :
    assert property (up == 3'h7 && $past(LEGACY_RESET_VPP_PIN_I, 3) &&
        $past(LEGACY_RESET_VPP_PIN_I, 4) && $past(LEGACY_RESET_VPP_PIN_I, 5) |-> !DEVICE_RESET_O)
        else $error("device held in reset while legacy reset pin high");
    erase_by_write_a :
    assert property (ERASE_BLOCK_O || ERASE_ROW_O |-> !(ERASE_BLOCK_O && ERASE_ROW_O) &&
        ($past(wr) || $past(wr, 2)))
        else $error("erase pulse without an erase write");
endmodule // pps_properties
bind pps_top pps_properties u_props (.*);
`default_nettype wire

// ===== pps_prog_model.sv
// Purpose: behavioural serial programmer on the far side of the port pins
// Assumes: link clock of 125 ns, held low outside frames
// Notes:   a released data line toggles so a stale level cannot pass
`timescale 1ns/1ps
`default_nettype none
module pps_prog_model (
    input  wire logic hv_i,
    input  wire logic lvp_i,
    input  wire logic ded_i,
    input  wire logic go_i,
    input  wire logic leg_q_i,
    input  wire logic leg_oe_n_i,
    input  wire logic ded_q_i,
    input  wire logic ded_oe_n_i,
    output var  logic busy_o,
    output var  logic mode_o,
    output wire logic leg_hv_o,
    output wire logic ded_hv_o,
    output wire logic leg_clk_o,
    output wire logic ded_clk_o,
    output wire logic leg_dat_o,
    output wire logic ded_dat_o
);
    logic       tick = 1'h0;
    logic       sck  = 1'h0;
    logic       drv  = 1'h0;
    logic       bq   = 1'h0;
    logic [7:0] pat  = 8'ha5;
    // free timebase, phase unrelated to the system clock
    initial #3.1 forever #62.5 tick = ~tick;
    initial begin
        busy_o = 1'h0;
        mode_o = 1'h0;
    end
    // entry pin a tick after the request, reset at supply; driven, no pull-up
    always @(posedge tick) mode_o <= lvp_i;
    // high voltage and clock reach the chosen port only
    assign leg_hv_o  = hv_i && !ded_i;
    assign ded_hv_o  = hv_i && ded_i;
    assign leg_clk_o = sck && !ded_i;
    assign ded_clk_o = sck && ded_i;
    // device drive wins, else model bit, else toggling
    assign leg_dat_o = !leg_oe_n_i ? leg_q_i : (drv && !ded_i) ? bq : tick;
    assign ded_dat_o = !ded_oe_n_i ? ded_q_i : (drv && ded_i) ? bq : tick;
    // eight bits, data moves while the clock is low
    always @(posedge go_i) begin
        busy_o = 1'h1;
        for (int n = 7; n >= 0; n--) begin
            @(negedge tick);
            sck = 1'h0;
            bq  = pat[n];
            drv = 1'h1;
            @(posedge tick);
            sck = 1'h1;
        end
        @(negedge tick);
        sck    = 1'h0;
        drv    = 1'h0;
        busy_o = 1'h0;
    end
endmodule // pps_prog_model
`default_nettype wire

// ===== testbench.sv
// Purpose: self-checking bench for the port select block
// Assumes: apb master drives by nba just after the edge
// Notes:   level outputs are read six edges after a pin move
`timescale 1ns/1ps
`default_nettype none
module testbench;
    typedef struct packed {
        logic        hv;
        logic [11:0] a;
        logic        w;
        logic [7:0]  d;
        logic [7:0]  x;
        logic        e;
    } pps_row_t;
    localparam int NROW = 19;
    logic        clk = 1'h0, rst_n = 1'h0, psel = 1'h0, pen = 1'h0, pwr = 1'h0;
    logic [11:0] paddr = 12'h000;
    logic [7:0]  sh = 8'h00;
    logic [31:0] pwd = 32'h0, prd, q;
    logic        prdy, perr, e, leg_lvl = 1'h1, ded_lvl = 1'h1, emu = 1'h1, sdo = 1'h0;
    logic        sdrv = 1'h0, hv = 1'h0, single_supply_prog_enable = 1'h0, sel = 1'h0, go = 1'h0, busy, mode;
    logic        lhv, dhv, lclk, dclk, ldat, ddat, lq, loe, dq, doe;
    logic        rise, fall, sdat, dres, pm, dbg, red, gpio, erb, erw;
    int          failures = 0, check_count = 0, cyc = 0, rises = 0, falls = 0, nrow = 0, nblk = 0;
    pps_row_t    rows [NROW] = '{
        '{1'h0, 12'h000, 1'h0, 8'h00, 8'h06, 1'h0}, '{1'h0, 12'h004, 1'h0, 8'h00, 8'h00, 1'h0},
        '{1'h0, 12'h00c, 1'h0, 8'h00, 8'h00, 1'h1}, '{1'h0, 12'h000, 1'h1, 8'h00, 8'h00, 1'h0},
        '{1'h0, 12'h000, 1'h0, 8'h00, 8'h06, 1'h0}, '{1'h0, 12'h004, 1'h0, 8'h00, 8'h40, 1'h0},
        '{1'h0, 12'h004, 1'h1, 8'h40, 8'h00, 1'h0}, '{1'h0, 12'h004, 1'h0, 8'h00, 8'h00, 1'h0},
        '{1'h1, 12'h000, 1'h1, 8'h00, 8'h00, 1'h0}, '{1'h1, 12'h000, 1'h0, 8'h00, 8'h00, 1'h0},
        '{1'h1, 12'h004, 1'h0, 8'h00, 8'h33, 1'h0}, '{1'h1, 12'h008, 1'h1, 8'h02, 8'h00, 1'h0},
        '{1'h1, 12'h000, 1'h1, 8'h08, 8'h00, 1'h0}, '{1'h1, 12'h008, 1'h1, 8'h02, 8'h00, 1'h0},
        '{1'h1, 12'h004, 1'h0, 8'h00, 8'hb3, 1'h0}, '{1'h1, 12'h008, 1'h1, 8'h03, 8'h00, 1'h0},
        '{1'h1, 12'h004, 1'h1, 8'h80, 8'h00, 1'h0}, '{1'h1, 12'h000, 1'h1, 8'h0d, 8'h00, 1'h0},
        '{1'h1, 12'h000, 1'h0, 8'h00, 8'h0d, 1'h0}};
    always #2.5 clk = ~clk;
    pps_top dut (.MCLK_I(clk), .RST_N_I(rst_n), .PSEL_I(psel), .PENABLE_I(pen),
        .PWRITE_I(pwr), .PADDR_I(paddr), .PWDATA_I(pwd), .PRDATA_O(prd), .PREADY_O(prdy),
        .PSLVERR_O(perr), .LEGACY_RESET_VPP_PIN_I(leg_lvl), .LEGACY_VPP_HV_I(lhv),
        .LEGACY_PROG_CLOCK_PIN_I(lclk), .LEGACY_PROG_DATA_PIN_I(ldat),
        .LEGACY_PROG_DATA_PIN_O(lq), .LEGACY_PROG_DATA_PIN_OE_N_O(loe),
        .DEDICATED_RESET_VPP_PIN_I(ded_lvl), .DEDICATED_VPP_HV_I(dhv),
        .DEDICATED_PROG_CLOCK_PIN_I(dclk), .DEDICATED_PROG_DATA_PIN_I(ddat),
        .DEDICATED_PROG_DATA_PIN_O(dq), .DEDICATED_PROG_DATA_PIN_OE_N_O(doe),
        .EMULATION_SELECT_PIN_I(emu), .PROG_MODE_ENTRY_PIN_I(mode), .SER_DATA_OUT_I(sdo),
        .SER_DATA_DRIVE_I(sdrv), .SER_CLK_RISE_O(rise), .SER_CLK_FALL_O(fall), .SER_DATA_O(sdat),
        .DEVICE_RESET_O(dres), .PROG_MODE_O(pm), .DEBUG_ENABLE_O(dbg),
        .REDUCED_PACKAGE_O(red), .MODE_PIN_GPIO_O(gpio), .ERASE_BLOCK_O(erb), .ERASE_ROW_O(erw));
    pps_prog_model prog (.hv_i(hv), .lvp_i(single_supply_prog_enable), .ded_i(sel), .go_i(go), .leg_q_i(lq),
        .leg_oe_n_i(loe), .ded_q_i(dq), .ded_oe_n_i(doe), .busy_o(busy), .mode_o(mode),
        .leg_hv_o(lhv), .ded_hv_o(dhv), .leg_clk_o(lclk), .ded_clk_o(dclk),
        .leg_dat_o(ldat), .ded_dat_o(ddat));
    // pulse counters and run ceiling
    always @(posedge clk) begin
        cyc++;
        if (rise === 1'h1) rises++;
        if (erb === 1'h1) nblk++;
        if (erw === 1'h1) nrow++;
        if (fall === 1'h1) falls++;
        if (rise === 1'h1) sh = {sh[6:0], sdat};
        if (cyc == 40000) begin
            failures++;
            final_report();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] want);
        check_count++;
        if (got !== want) begin
            failures++;
            $display("Error at %0t: got %h expected %h", $time, got, want);
        end
    endtask
    task automatic settle();
        repeat (6) @(posedge clk);
    endtask
    // setup, then access held until ready seen at an edge
    task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
        @(posedge clk);
        psel  <= 1'h1;
        pen   <= 1'h0;
        pwr   <= w;
        paddr <= a;
        pwd   <= d;
        @(posedge clk);
        pen <= 1'h1;
        do begin
            @(posedge clk);
        end while (prdy !== 1'h1);
        q = prd;
        e = perr;
        psel <= 1'h0;
        pen  <= 1'h0;
    endtask
    task automatic wait_pm(input logic v);
        int t;
        t = 0;
        do begin
            @(posedge clk);
            t++;
        end while (pm !== v && t < 400);
        chk({31'h0, pm}, {31'h0, v});
    endtask
    task automatic frame(input logic d, input int n);
        int t;
        t = 0;
        sel <= d;
        @(posedge clk);
        rises = 0;
        falls = 0;
        go <= 1'h1;
        do begin
            @(posedge clk);
            t++;
        end while ((busy === 1'h1 || t < 3) && t < 3000);
        go <= 1'h0;
        settle();
        chk(rises, n);
        chk(falls, n);
        if (n > 0) chk({24'h0, sh}, 32'ha5);
    endtask
    task automatic final_report();
        $display("checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    initial begin
        repeat (5) @(posedge clk);
        rst_n <= 1'h1;
        for (int i = 0; i < NROW; i++) begin
            if (hv !== rows[i].hv) begin
                hv <= rows[i].hv;
                wait_pm(rows[i].hv);
            end
            apb(rows[i].a, rows[i].w, {24'h0, rows[i].d});
            if (rows[i].w === 1'h0) chk(q, {24'h0, rows[i].x});
            chk({31'h0, e}, {31'h0, rows[i].e});
        end
        chk(nrow, 1);
        chk(nblk, 1);
        hv <= 1'h0;
        wait_pm(1'h0);
        frame(1'h0, 8);
        leg_lvl <= 1'h0;
        frame(1'h1, 8);
        chk({31'h0, dres}, 32'h0);
        sdrv    <= 1'h1;
        sdo     <= 1'h1;
        settle();
        chk({28'h0, lq, loe, doe, dq}, 32'hd);
        sdrv    <= 1'h0;
        ded_lvl <= 1'h0;
        settle();
        chk({31'h0, dres}, 32'h1);
        leg_lvl <= 1'h1;
        settle();
        chk({31'h0, dres}, 32'h0);
        ded_lvl <= 1'h1;
        leg_lvl <= 1'h0;
        emu     <= 1'h0;
        settle();
        chk({31'h0, red}, 32'h1);
        emu <= 1'h1;
        settle();
        chk({31'h0, red}, 32'h0);
        sel <= 1'h1;
        hv  <= 1'h1;
        wait_pm(1'h1);
        apb(12'h000, 1'h1, 32'hc);
        apb(12'h000, 1'h0, 32'h0);
        chk(q, 32'hd);
        hv <= 1'h0;
        wait_pm(1'h0);
        sel     <= 1'h0;
        leg_lvl <= 1'h1;
        single_supply_prog_enable     <= 1'h1;
        wait_pm(1'h1);
        apb(12'h000, 1'h1, 32'h9);
        apb(12'h000, 1'h0, 32'h0);
        chk(q, 32'hd);
        single_supply_prog_enable <= 1'h0;
        wait_pm(1'h0);
        hv <= 1'h1;
        wait_pm(1'h1);
        apb(12'h000, 1'h1, 32'h8);
        hv <= 1'h0;
        wait_pm(1'h0);
        chk({31'h0, gpio}, 32'h1);
        single_supply_prog_enable <= 1'h1;
        repeat (60) @(posedge clk);
        chk({31'h0, pm}, 32'h0);
        single_supply_prog_enable     <= 1'h0;
        leg_lvl <= 1'h0;
        frame(1'h1, 0);
        rst_n <= 1'h0;
        repeat (5) @(posedge clk);
        rst_n <= 1'h1;
        apb(12'h000, 1'h0, 32'h0);
        chk(q, 32'h6);
        chk({31'h0, dbg}, 32'h0);
        final_report();
    end
endmodule // testbench
`default_nettype wire
